// >>> core/pdrc_params.svh
// timing counts and field limits for the power-down and reset controller
// assumes a 250 MHz core clock with its period held in ps; all other times are held in ns and turned into
// core clock cycles here
`ifndef PDRC_PARAMS_SVH
`define PDRC_PARAMS_SVH
`define CLK_PERIOD_PS 4000
`define CYC_UP(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CPDED_NS 8
`define EXIT_LAT_NS 6
`define EXIT_LAT_DLL_NS 24
`define ANPD_NS 9
`define WR_MIN_NS 15
`define REFRESH_INTERVAL_NS 7800
`define PD_MAX_INTERVALS 9
`define CPDED_CYC `CYC_UP(`CPDED_NS)
`define EXIT_LAT_CYC `CYC_UP(`EXIT_LAT_NS)
`define EXIT_LAT_DLL_CYC `CYC_UP(`EXIT_LAT_DLL_NS)
`define ASYNC_HOLD_CYC `CYC_UP(`ANPD_NS + `EXIT_LAT_DLL_NS)
`define WR_COUNT_CYC `CYC_UP(`WR_MIN_NS)
`define PD_MAX_CYC (`PD_MAX_INTERVALS * `CYC_UP(`REFRESH_INTERVAL_NS))
`define TIMER_W 8
`define PD_DUR_W 17
`define TERM_FIELD_MAX 3'h5
`endif

// >>> core/pdrc_pkg.sv
// types shared by the power-down and reset controller
// assumes pdrc_params.svh holds all numbers
package pdrc_pkg;
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_ENTRY   = 3'b001,
    ST_PD_ACT  = 3'b010,
    ST_PD_FAST = 3'b011,
    ST_PD_SLOW = 3'b100,
    ST_RESET   = 3'b101
  } pd_state_type;
endpackage

// >>> core/link_if.sv
// events and levels passed from the link clock domain to the core
// assumes the receiver synchronises every signal before use
interface link_if;
  logic entry_tgl;
  logic exit_tgl;
  logic term_level;
  modport src (output entry_tgl, output exit_tgl, output term_level);
  modport dst (input entry_tgl, input exit_tgl, input term_level);
endinterface

// >>> core/link_sampler.sv
// link-side capture of clock enable, command and termination pins
// assumes pins are launched by the controller on the link clock
module link_sampler (
  input  wire logic i_link_clk,
  input  wire logic i_srst,
  input  wire logic i_cke,
  input  wire logic i_nop_or_des,
  input  wire logic i_term_ctl,
  link_if.src       lnk
);
  logic rst_s1_r;
  logic rst_s2_r;
  logic cke_r;
  logic entry_tgl_r;
  logic exit_tgl_r;
  logic term_r;

  // core reset reaches this domain through two flops
  always_ff @(posedge i_link_clk) begin
    rst_s1_r <= i_srst;
    rst_s2_r <= rst_s1_r;
  end

  always_ff @(posedge i_link_clk) begin
    if (rst_s2_r) begin
      cke_r       <= 1'b1;
      entry_tgl_r <= 1'b0;
      exit_tgl_r  <= 1'b0;
    end else begin
      cke_r <= i_cke;
      if (cke_r && !i_cke && i_nop_or_des) begin
        entry_tgl_r <= ~entry_tgl_r;
      end
      if (!cke_r && i_cke && i_nop_or_des) begin
        exit_tgl_r <= ~exit_tgl_r;
      end
    end
  end

  // a level held in a flop so the core sees a glitch-free source
  always_ff @(posedge i_link_clk) begin
    if (rst_s2_r) begin
      term_r <= 1'b0;
    end else begin
      term_r <= i_term_ctl;
    end
  end

  assign lnk.entry_tgl  = entry_tgl_r;
  assign lnk.exit_tgl   = exit_tgl_r;
  assign lnk.term_level = term_r;
endmodule

// >>> core/dram_power_down_reset_control.sv
// power-down entry and exit, chip clear and termination gating
// assumes link pins arrive on i_link_clk; mode bits and bank status come
// from logic on i_clk
// Contract
// - buffers off after entry delay, except pins
// - open bank gives active, else precharge
// - exit mode bit picks fast or slow
// - active power-down keeps loop, fast exit
// - clear low during power-down forces reset
// - enable high with no-op exits power-down
// - write recovery count is time rounded up
// - chip clear acts at any time
// - reset disables outputs, termination, refresh counters
// - termination ignored in self refresh or disabled
// - termination asynchronous while loop off
// - dynamic termination only in write bursts
// - nominal termination field and pin gate it
// - enable low with no-op enters power-down
// - slow exit keeps termination asynchronous longer
`include "pdrc_params.svh"
module dram_power_down_reset_control #(
  parameter logic [`PD_DUR_W-1:0] PD_MAX_CYCLES = `PD_DUR_W'(`PD_MAX_CYC)
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  input  wire logic       i_link_clk,
  input  wire logic       i_cke,
  input  wire logic       i_nop_or_des,
  input  wire logic       i_term_ctl,
  input  wire logic       i_chip_clear_n,
  input  wire logic       i_busy,
  input  wire logic       i_bank_open,
  input  wire logic       i_pd_exit_mode,
  input  wire logic [2:0] i_nom_term_field,
  input  wire logic       i_self_refresh,
  input  wire logic       i_dll_disable_mode,
  input  wire logic       i_dll_synchronizing,
  input  wire logic       i_dyn_term_en,
  input  wire logic       i_write_burst,
  input  wire logic       i_init_done,
  output logic            o_pd_active,
  output logic            o_pd_precharge,
  output logic            o_dll_on,
  output logic            o_buffers_on,
  output logic            o_out_enable,
  output logic            o_term_on,
  output logic            o_term_async,
  output logic            o_term_dynamic,
  output logic            o_refresh_clear,
  output logic            o_needs_init,
  output logic            o_exit_ready,
  output logic            o_dll_ready,
  output logic            o_pd_overtime,
  output logic [3:0]      o_write_recovery_count
);
  localparam logic [`TIMER_W-1:0] CPDED_C = `TIMER_W'(`CPDED_CYC);
  localparam logic [`TIMER_W-1:0] XP_C    = `TIMER_W'(`EXIT_LAT_CYC);
  localparam logic [`TIMER_W-1:0] XPDLL_C = `TIMER_W'(`EXIT_LAT_DLL_CYC);
  localparam logic [`TIMER_W-1:0] HOLD_C  = `TIMER_W'(`ASYNC_HOLD_CYC);
  localparam logic [3:0]          WR_C    = 4'(`WR_COUNT_CYC);

  link_if lnk ();

  pdrc_pkg::pd_state_type state_r;
  pdrc_pkg::pd_state_type state_nxt;
  logic                   clr_s1_r;
  logic                   clr_s2_r;
  logic                   ent_s1_r;
  logic                   ent_s2_r;
  logic                   ent_s3_r;
  logic                   ext_s1_r;
  logic                   ext_s2_r;
  logic                   ext_s3_r;
  logic                   term_s1_r;
  logic                   term_s2_r;
  logic                   entry_evt;
  logic                   exit_evt;
  logic                   in_pd;
  logic                   nom_term_en;
  logic [`TIMER_W-1:0]    cpded_cnt_r;
  logic [`TIMER_W-1:0]    xp_cnt_r;
  logic [`TIMER_W-1:0]    xpdll_cnt_r;
  logic [`TIMER_W-1:0]    hold_cnt_r;
  logic [`PD_DUR_W-1:0]   pd_dur_r;

  link_sampler u_link (
    .i_link_clk   (i_link_clk),
    .i_srst       (i_srst),
    .i_cke        (i_cke),
    .i_nop_or_des (i_nop_or_des),
    .i_term_ctl   (i_term_ctl),
    .lnk          (lnk)
  );

  // every crossing signal passes two flops; events are toggle edges
  // taken between the second and third flop
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clr_s1_r  <= 1'b1;
      clr_s2_r  <= 1'b1;
      ent_s1_r  <= 1'b0;
      ent_s2_r  <= 1'b0;
      ent_s3_r  <= 1'b0;
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_s3_r  <= 1'b0;
      term_s1_r <= 1'b0;
      term_s2_r <= 1'b0;
    end else if (i_ce) begin
      clr_s1_r  <= i_chip_clear_n;
      clr_s2_r  <= clr_s1_r;
      ent_s1_r  <= lnk.entry_tgl;
      ent_s2_r  <= ent_s1_r;
      ent_s3_r  <= ent_s2_r;
      ext_s1_r  <= lnk.exit_tgl;
      ext_s2_r  <= ext_s1_r;
      ext_s3_r  <= ext_s2_r;
      term_s1_r <= lnk.term_level;
      term_s2_r <= term_s1_r;
    end
  end

  assign entry_evt = ent_s2_r ^ ent_s3_r;
  assign exit_evt  = ext_s2_r ^ ext_s3_r;
  assign in_pd     = (state_r == pdrc_pkg::ST_PD_ACT) ||
                     (state_r == pdrc_pkg::ST_PD_FAST) ||
                     (state_r == pdrc_pkg::ST_PD_SLOW);
  // codes above five are reserved and never enable termination
  assign nom_term_en = (i_nom_term_field != 3'h0) &&
                       (i_nom_term_field <= `TERM_FIELD_MAX);

  always_comb begin
    state_nxt = state_r;
    if (!clr_s2_r) begin
      state_nxt = pdrc_pkg::ST_RESET;
    end else begin
      unique case (state_r)
        pdrc_pkg::ST_RUN: begin
          if (entry_evt) begin
            state_nxt = pdrc_pkg::ST_ENTRY;
          end
        end
        pdrc_pkg::ST_ENTRY: begin
          if (exit_evt) begin
            state_nxt = pdrc_pkg::ST_RUN;
          end else if (!i_busy) begin
            if (i_bank_open) begin
              state_nxt = pdrc_pkg::ST_PD_ACT;
            end else if (i_pd_exit_mode) begin
              state_nxt = pdrc_pkg::ST_PD_FAST;
            end else begin
              state_nxt = pdrc_pkg::ST_PD_SLOW;
            end
          end
        end
        pdrc_pkg::ST_PD_ACT,
        pdrc_pkg::ST_PD_FAST,
        pdrc_pkg::ST_PD_SLOW: begin
          if (exit_evt) begin
            state_nxt = pdrc_pkg::ST_RUN;
          end
        end
        pdrc_pkg::ST_RESET: state_nxt = pdrc_pkg::ST_RUN;
        default: state_nxt = pdrc_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= pdrc_pkg::ST_RUN;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // entry delay before the buffers drop
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cpded_cnt_r <= CPDED_C;
    end else if (i_ce) begin
      if (state_r == pdrc_pkg::ST_RUN) begin
        cpded_cnt_r <= CPDED_C;
      end else if (cpded_cnt_r != '0) begin
        cpded_cnt_r <= cpded_cnt_r - 1'b1;
      end
    end
  end

  // exit latencies; the loop latency only applies after a slow exit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      xp_cnt_r    <= '0;
      xpdll_cnt_r <= '0;
      hold_cnt_r  <= '0;
    end else if (i_ce) begin
      if (exit_evt && in_pd && clr_s2_r) begin
        xp_cnt_r <= XP_C;
        if (state_r == pdrc_pkg::ST_PD_SLOW) begin
          xpdll_cnt_r <= XPDLL_C;
          hold_cnt_r  <= HOLD_C;
        end
      end else begin
        if (xp_cnt_r != '0) begin
          xp_cnt_r <= xp_cnt_r - 1'b1;
        end
        if (xpdll_cnt_r != '0) begin
          xpdll_cnt_r <= xpdll_cnt_r - 1'b1;
        end
        if (hold_cnt_r != '0) begin
          hold_cnt_r <= hold_cnt_r - 1'b1;
        end
      end
    end
  end

  // saturating duration counter flags an over-long power-down
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pd_dur_r <= '0;
    end else if (i_ce) begin
      if (!in_pd) begin
        pd_dur_r <= '0;
      end else if (pd_dur_r != PD_MAX_CYCLES) begin
        pd_dur_r <= pd_dur_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pd_active    <= 1'b0;
      o_pd_precharge <= 1'b0;
      o_dll_on       <= 1'b1;
      o_buffers_on   <= 1'b1;
      o_out_enable   <= 1'b1;
      o_term_async   <= 1'b0;
      o_pd_overtime  <= 1'b0;
      o_exit_ready   <= 1'b1;
      o_dll_ready    <= 1'b1;
    end else if (i_ce) begin
      o_pd_active    <= state_r == pdrc_pkg::ST_PD_ACT;
      o_pd_precharge <= (state_r == pdrc_pkg::ST_PD_FAST) ||
                        (state_r == pdrc_pkg::ST_PD_SLOW);
      o_dll_on       <= (state_r != pdrc_pkg::ST_PD_SLOW) &&
                        (state_r != pdrc_pkg::ST_RESET);
      o_buffers_on   <= !(state_r != pdrc_pkg::ST_RUN &&
                          cpded_cnt_r == '0);
      o_out_enable   <= state_r != pdrc_pkg::ST_RESET;
      o_term_async   <= (state_r == pdrc_pkg::ST_PD_SLOW) ||
                        (hold_cnt_r != '0) ||
                        i_dll_synchronizing;
      o_pd_overtime  <= pd_dur_r == PD_MAX_CYCLES;
      o_exit_ready   <= xp_cnt_r == '0;
      o_dll_ready    <= xpdll_cnt_r == '0;
    end
  end

  // termination is gated by reset, self refresh, mode and loop state
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_term_on      <= 1'b0;
      o_term_dynamic <= 1'b0;
    end else if (i_ce) begin
      o_term_on      <= nom_term_en && term_s2_r && !i_self_refresh &&
                        !i_dll_disable_mode &&
                        (state_r != pdrc_pkg::ST_RESET);
      o_term_dynamic <= i_dyn_term_en && i_write_burst && term_s2_r &&
                        !i_self_refresh && !i_dll_disable_mode &&
                        (state_r != pdrc_pkg::ST_RESET);
    end
  end

  // stored data is lost on reset, so init stays owed until told done
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_refresh_clear        <= 1'b0;
      o_needs_init           <= 1'b0;
      o_write_recovery_count <= WR_C;
    end else if (i_ce) begin
      o_refresh_clear        <= state_r == pdrc_pkg::ST_RESET;
      o_write_recovery_count <= WR_C;
      if (state_r == pdrc_pkg::ST_RESET) begin
        o_needs_init <= 1'b1;
      end else if (i_init_done) begin
        o_needs_init <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_clear_forces_reset: assert property (
    i_ce && !clr_s2_r |=> state_r == pdrc_pkg::ST_RESET)
    else $error("clear did not force reset");
  a_reset_outs_off: assert property (
    state_r == pdrc_pkg::ST_RESET && i_ce |=>
      !o_out_enable && !o_term_on && o_refresh_clear)
    else $error("reset left outputs or termination on");
  a_open_bank_active: assert property (
    state_r == pdrc_pkg::ST_ENTRY && i_ce && clr_s2_r && !exit_evt &&
    !i_busy && i_bank_open |=> state_r == pdrc_pkg::ST_PD_ACT)
    else $error("open bank did not give active power-down");
  a_slow_dll_off: assert property (
    state_r == pdrc_pkg::ST_ENTRY && i_ce && clr_s2_r && !exit_evt &&
    !i_busy && !i_bank_open && !i_pd_exit_mode
    |=> state_r == pdrc_pkg::ST_PD_SLOW ##1 (!i_ce || !o_dll_on))
    else $error("slow precharge power-down kept loop on");
  a_active_dll_on: assert property (
    state_r == pdrc_pkg::ST_PD_ACT && i_ce |=> o_dll_on)
    else $error("active power-down stopped the loop");
  // the ready flag is registered from the counter, so it drops one edge late
  a_exit_to_run: assert property (
    in_pd && exit_evt && i_ce && clr_s2_r
    |=> state_r == pdrc_pkg::ST_RUN ##1 (!$past(i_ce) || !o_exit_ready))
    else $error("exit not taken");
  a_buffers_drop: assert property (
    state_r == pdrc_pkg::ST_PD_ACT && cpded_cnt_r == '0 && i_ce
    |=> !o_buffers_on)
    else $error("buffers stayed on in power-down");
  a_selfref_no_term: assert property (
    i_ce && i_self_refresh |=> !o_term_on && !o_term_dynamic)
    else $error("termination in self refresh");
  a_slow_term_async: assert property (
    state_r == pdrc_pkg::ST_PD_SLOW && exit_evt && i_ce && clr_s2_r
    |=> (!i_ce || o_term_async) [*3])
    else $error("termination went synchronous too early");
  a_dyn_write_only: assert property (
    i_ce && !i_write_burst |=> !o_term_dynamic)
    else $error("dynamic termination outside write");

  c_active_pd: cover property (state_r == pdrc_pkg::ST_PD_ACT);
  c_slow_exit: cover property (
    state_r == pdrc_pkg::ST_PD_SLOW ##1 state_r == pdrc_pkg::ST_RUN);
  c_reset_in_pd: cover property (in_pd ##1 state_r == pdrc_pkg::ST_RESET);
endmodule

// >>> test/pd_ctrl_model.sv
// memory-controller model driving the link pins of the device
// assumes a free-running device clock; pins move just after its rising edge
module pd_ctrl_model (
  input  wire logic i_link_clk,
  output logic      o_cke,
  output logic      o_nop,
  output logic      o_term,
  output logic      o_clear_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cke = 1'b1;
    o_nop = 1'b1;
    o_term = 1'b0;
    o_clear_n = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_link_clk);
    // off every core clock edge, so bench waits count edges without a race
    #2;
  endtask

  // nop low is only used to provoke a refused entry
  task automatic enter(input logic no_operation_command);
    cyc(1);
    o_nop = no_operation_command;
    o_cke = 1'b0;
    cyc(1);
    o_nop = 1'b1;
    cyc(2);
  endtask

  // exit with a no-op, then hold enable and wait out both latencies
  task automatic leave();
    cyc(1);
    o_nop = 1'b1;
    o_cke = 1'b1;
    cyc(3);
  endtask

  // enable is driven low in the same step as the clear pin
  task automatic clear_pin(input logic v);
    cyc(1);
    o_cke = 1'b0;
    o_clear_n = v;
    cyc(3);
  endtask

  task automatic term_pin(input logic v);
    cyc(1);
    o_term = v;
    cyc(1);
  endtask
endmodule

// >>> test/test_dram_power_down_reset_control.sv
// self-checking bench for the power-down and reset controller
// assumes the controller model on the link pins and core inputs on i_clk
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_dram_power_down_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_srst;
  logic i_ce;
  logic i_busy;
  logic i_bank_open;
  logic i_pd_exit_mode;
  logic [2:0] i_nom_term_field;
  logic i_self_refresh;
  logic i_dll_disable_mode;
  logic i_dll_synchronizing;
  logic i_dyn_term_en;
  logic i_write_burst;
  logic i_init_done;
  logic cke, no_operation_command, term, clear_n;
  logic pd_act, pd_pre, dll_on, buf_on, out_en, term_on, term_async;
  logic term_dyn, ref_clr, needs_init, exit_rdy, dll_rdy, overtime;
  logic [3:0] wr_cnt;
  int n_fail = 0;
  int samples_checked = 0;
  int n_dll_low = 0;
  int n_exit_low = 0;
  int cyc_cnt = 0;

  always #2 i_clk = ~i_clk;
  // link clock offset so its edges never line up with the core clock
  initial begin
    #7;
    forever #40 i_link_clk = ~i_link_clk;
  end

  pd_ctrl_model ctl (.i_link_clk(i_link_clk), .o_cke(cke), .o_nop(no_operation_command),
    .o_term(term), .o_clear_n(clear_n));

  dram_power_down_reset_control #(.PD_MAX_CYCLES(17'h00014)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_link_clk(i_link_clk),
    .i_cke(cke), .i_nop_or_des(no_operation_command), .i_term_ctl(term),
    .i_chip_clear_n(clear_n), .i_busy(i_busy), .i_bank_open(i_bank_open),
    .i_pd_exit_mode(i_pd_exit_mode), .i_nom_term_field(i_nom_term_field),
    .i_self_refresh(i_self_refresh), .i_dll_disable_mode(i_dll_disable_mode),
    .i_dll_synchronizing(i_dll_synchronizing),
    .i_dyn_term_en(i_dyn_term_en), .i_write_burst(i_write_burst),
    .i_init_done(i_init_done), .o_pd_active(pd_act),
    .o_pd_precharge(pd_pre), .o_dll_on(dll_on), .o_buffers_on(buf_on),
    .o_out_enable(out_en), .o_term_on(term_on), .o_term_async(term_async),
    .o_term_dynamic(term_dyn), .o_refresh_clear(ref_clr),
    .o_needs_init(needs_init), .o_exit_ready(exit_rdy),
    .o_dll_ready(dll_rdy), .o_pd_overtime(overtime),
    .o_write_recovery_count(wr_cnt));

  // low-cycle counters for the exit latency windows; sampled on the
  // falling edge, where the registered outputs have settled
  always @(negedge i_clk) begin
    if (dll_rdy !== 1'b1) n_dll_low++;
    if (exit_rdy !== 1'b1) n_exit_low++;
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic nc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic pd_check(input logic a, input logic p, input logic d);
    `CHK(pd_act, a)
    `CHK(pd_pre, p)
    `CHK(dll_on, d)
    `CHK(buf_on, 1'b0)
    `CHK(overtime, 1'b1)
  endtask

  initial begin
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_busy = 1'b0;
    i_bank_open = 1'b0;
    i_pd_exit_mode = 1'b1;
    i_nom_term_field = 3'h1;
    i_self_refresh = 1'b0;
    i_dll_disable_mode = 1'b0;
    i_dll_synchronizing = 1'b0;
    i_dyn_term_en = 1'b0;
    i_write_burst = 1'b0;
    i_init_done = 1'b0;
    // link flops need a few link edges inside reset as well
    nc(4);
    repeat (3) @(posedge i_link_clk);
    nc(1);
    i_srst = 1'b0;
    repeat (4) @(posedge i_link_clk);
    nc(2);
    `CHK({dll_on, buf_on, out_en, exit_rdy, dll_rdy}, 5'h1f)
    `CHK({pd_act, pd_pre, ref_clr, needs_init, overtime}, 5'h00)
    `CHK(wr_cnt, 4'h4)
    ctl.term_pin(1'b1);
    nc(1);
    for (int f = 0; f < 8; f++) begin
      i_nom_term_field = 3'(f);
      nc(3);
      `CHK(term_on, (f >= 1 && f <= 5))
    end
    i_nom_term_field = 3'h2;
    i_self_refresh = 1'b1;
    nc(3);
    `CHK(term_on, 1'b0)
    i_self_refresh = 1'b0;
    i_dll_disable_mode = 1'b1;
    nc(3);
    `CHK(term_on, 1'b0)
    i_dll_disable_mode = 1'b0;
    i_dll_synchronizing = 1'b1;
    nc(3);
    `CHK(term_async, 1'b1)
    i_dll_synchronizing = 1'b0;
    i_dyn_term_en = 1'b1;
    i_write_burst = 1'b1;
    nc(3);
    `CHK(term_dyn, 1'b1)
    i_write_burst = 1'b0;
    nc(3);
    `CHK({term_dyn, term_on}, 2'h1)
    ctl.term_pin(1'b0);
    nc(3);
    `CHK(term_on, 1'b0)
    ctl.enter(1'b0);
    nc(2);
    `CHK({pd_act, pd_pre, buf_on}, 3'h1)
    ctl.leave();
    nc(1);
    i_bank_open = 1'b1;
    i_pd_exit_mode = 1'b0;
    i_busy = 1'b1;
    ctl.enter(1'b1);
    nc(1);
    `CHK({pd_act, pd_pre}, 2'h0)
    i_busy = 1'b0;
    ctl.cyc(2);
    nc(1);
    pd_check(1'b1, 1'b0, 1'b1);
    n_dll_low = 0;
    n_exit_low = 0;
    ctl.leave();
    nc(1);
    `CHK({pd_act, buf_on}, 2'h1)
    `CHK(n_exit_low, 2)
    `CHK(n_dll_low, 0)
    i_bank_open = 1'b0;
    i_pd_exit_mode = 1'b1;
    ctl.enter(1'b1);
    nc(1);
    pd_check(1'b0, 1'b1, 1'b1);
    ctl.leave();
    nc(1);
    i_pd_exit_mode = 1'b0;
    ctl.enter(1'b1);
    nc(1);
    pd_check(1'b0, 1'b1, 1'b0);
    `CHK(term_async, 1'b1)
    n_dll_low = 0;
    n_exit_low = 0;
    ctl.leave();
    nc(1);
    `CHK({pd_pre, dll_on, term_async}, 3'h2)
    `CHK(n_dll_low, 6)
    `CHK(n_exit_low, 2)
    i_bank_open = 1'b1;
    ctl.term_pin(1'b1);
    ctl.enter(1'b1);
    ctl.clear_pin(1'b0);
    nc(1);
    `CHK({pd_act, out_en, term_on, ref_clr}, 4'h1)
    ctl.clear_pin(1'b1);
    nc(1);
    `CHK({out_en, needs_init, ref_clr}, 3'h6)
    i_init_done = 1'b1;
    nc(1);
    i_init_done = 1'b0;
    nc(2);
    `CHK(needs_init, 1'b0)
    // clock enable low must freeze the termination gate
    i_ce = 1'b0;
    i_self_refresh = 1'b1;
    nc(3);
    `CHK(term_on, 1'b1)
    i_ce = 1'b1;
    nc(3);
    `CHK(term_on, 1'b0)
    i_self_refresh = 1'b0;
    end_sim();
  end
endmodule
